// *** shared/flash_pkg.sv ***
// constants, codes and query table shared by both ends of the flash bus
// How it works
// - host writes 60h setup to a block
// - host confirms with D0h, unprotect starts
// - poll status by strobing until ready b7
// - bad program supply sets status b3
// - b4 and b5 together: bad sequence
// - b5 alone: unprotect failed, else success
// - host writes FFh to return to array
// - errors stick until clear-status command
// - query 3Fh returns 01h
// - query 40h/41h return 80h/00h
// - query 42h returns 03h
// - query 43h returns 03h
// - query 44h returns 04h
// - query 45h returns 03h
// - query 46h/47h return 01h/02h
// - query 3Bh returns 01h
package flash_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  // command codes on dq[7:0]
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_UNPROT_SETUP = 8'h60;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  // status bit positions
  localparam int ST_READY      = 7;
  localparam int ST_UNPROT_ERR = 5;
  localparam int ST_SEQ_ERR    = 4;
  localparam int ST_VPP_ERR    = 3;
  // unprotect duration
  localparam int CLOCK_PERIOD_NS   = 20;
  localparam int UNPROTECT_TIME_NS = 1000;
  localparam int UNPROTECT_CYCLES  =
    (UNPROTECT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // host bus cycle phases
  localparam logic [2:0] PH_STROBE_ON  = 3'h1;
  localparam logic [2:0] PH_SAMPLE     = 3'h3;
  localparam logic [2:0] PH_LAST       = 3'h4;
  // query table: {offset, value}
  localparam int QUERY_N = 12;
  localparam logic [15:0] QUERY_TABLE [QUERY_N] = '{
    {8'h3b, 8'h01},
    {8'h3f, 8'h01},
    {8'h40, 8'h80},
    {8'h41, 8'h00},
    {8'h42, 8'h03},
    {8'h43, 8'h03},
    {8'h44, 8'h04},
    {8'h45, 8'h03},
    {8'h46, 8'h01},
    {8'h47, 8'h02},
    {8'h48, 8'h07},
    {8'h3c, 8'h00}
  };
  typedef enum logic [1:0] {
    RES_OK   = 2'b00,
    RES_VPP  = 2'b01,
    RES_SEQ  = 2'b10,
    RES_FAIL = 2'b11
  } result_type;
endpackage

// *** shared/flash_bus_if.sv ***
// parallel flash bus between host and device, with dq resolution
`timescale 1ns/1ps
`default_nettype none
interface flash_bus_if import flash_pkg::*; ();
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_host;
  logic              dq_host_oe;
  logic [DATA_W-1:0] dq_dev;
  logic              dq_dev_oe;
  logic [DATA_W-1:0] dq;
  // wire level, pulled high when nobody drives
  assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : {DATA_W{1'b1}});
  modport device (
    input  ce_n, oe_n, we_n, addr, dq,
    output dq_dev, dq_dev_oe
  );
  modport host (
    output ce_n, oe_n, we_n, addr, dq_host, dq_host_oe,
    input  dq
  );
endinterface
`default_nettype wire

// *** rtl/flash_device.sv ***
// flash device end: command interpreter, unprotect engine, status, query
`timescale 1ns/1ps
`default_nettype none
module flash_device import flash_pkg::*; #(
  parameter int UNPROTECT_COUNT = UNPROTECT_CYCLES,
  parameter int CNT_W           = 16
) (
  input  wire logic              CLOCK,       // 50 mhz clock
  input  wire logic              NRST,        // async reset, low
  flash_bus_if.device            BUS,         // parallel flash bus
  input  wire logic              VPP_OK,      // program supply valid
  input  wire logic              FAIL_INJECT, // unprotect will fail
  input  wire logic              PROTECT_ALL, // set protection bits
  input  wire logic [DATA_W-1:0] ARRAY_DATA,  // word shown in array mode
  output logic                   BUSY,        // unprotect running
  output logic                   PROTECTED,   // blocks protected
  output logic [7:0]             STATUS       // status byte
);
  typedef enum logic [2:0] {
    M_ARRAY  = 3'b000,
    M_STATUS = 3'b001,
    M_QUERY  = 3'b010,
    M_SETUP  = 3'b011,
    M_BUSY   = 3'b100
  } mode_type;

  mode_type          mode;
  mode_type          next_mode;
  logic              we_q;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              vpp_bad;
  logic              next_vpp_bad;
  logic              st_vpp;
  logic              next_st_vpp;
  logic              st_seq;
  logic              next_st_seq;
  logic              st_fail;
  logic              next_st_fail;
  logic              prot;
  logic              next_prot;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;
  logic              rd_oe;
  logic              next_rd_oe;
  logic              we_rise;
  logic [7:0]        cmd;
  logic [7:0]        status_byte;
  logic              any_err;

  // query lookup, zero outside the table
  function automatic logic [DATA_W-1:0] query_word(input logic [7:0] off);
    logic [DATA_W-1:0] w;
    w = '0;
    for (int i = 0; i < QUERY_N; i++) begin
      if (QUERY_TABLE[i][15:8] == off) begin
        w = {8'h00, QUERY_TABLE[i][7:0]};
      end
    end
    return w;
  endfunction

  // write strobe end and command byte
  assign we_rise = !BUS.ce_n && !we_q && BUS.we_n;
  assign cmd     = BUS.dq[7:0];
  assign any_err = st_vpp || st_seq || st_fail;

  // status byte assembly
  always_comb begin
    status_byte                = 8'h00;
    status_byte[ST_READY]      = (mode != M_BUSY);
    status_byte[ST_UNPROT_ERR] = st_fail || st_seq;
    status_byte[ST_SEQ_ERR]    = st_seq;
    status_byte[ST_VPP_ERR]    = st_vpp;
  end

  // command decode and unprotect engine
  always_comb begin
    next_mode    = mode;
    next_cnt     = cnt;
    next_vpp_bad = vpp_bad;
    next_st_vpp  = st_vpp;
    next_st_seq  = st_seq;
    next_st_fail = st_fail;
    next_prot    = prot;
    if (mode == M_BUSY) begin
      if (!VPP_OK) begin
        next_vpp_bad = 1'b1;
      end
      if (cnt == CNT_W'(UNPROTECT_COUNT - 1)) begin
        next_mode = M_STATUS;
        next_cnt  = '0;
        if (vpp_bad || !VPP_OK) begin
          next_st_vpp = 1'b1;
        end else if (FAIL_INJECT) begin
          next_st_fail = 1'b1;
        end else begin
          next_prot = 1'b0;
        end
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end else if (mode == M_SETUP) begin
      if (we_rise) begin
        if (cmd == CMD_CONFIRM) begin
          next_mode    = M_BUSY;
          next_cnt     = '0;
          next_vpp_bad = 1'b0;
        end else begin
          next_st_seq = 1'b1;
          next_mode   = M_STATUS;
        end
      end
    end else if (we_rise) begin
      unique case (cmd)
        CMD_READ_ARRAY: begin
          next_mode = M_ARRAY;
        end
        CMD_READ_STATUS: begin
          next_mode = M_STATUS;
        end
        CMD_READ_QUERY: begin
          next_mode = M_QUERY;
        end
        CMD_CLEAR_STATUS: begin
          next_st_vpp  = 1'b0;
          next_st_seq  = 1'b0;
          next_st_fail = 1'b0;
        end
        CMD_UNPROT_SETUP: begin
          next_mode = M_SETUP;
        end
        default: begin
          next_mode = mode;
        end
      endcase
    end
    if (PROTECT_ALL && mode != M_BUSY) begin
      next_prot = 1'b1;
    end
  end

  // read data path, registered onto dq
  always_comb begin
    next_rd_oe   = !BUS.ce_n && !BUS.oe_n;
    next_rd_data = {8'h00, status_byte};
    unique case (mode)
      M_ARRAY: begin
        next_rd_data = ARRAY_DATA;
      end
      M_QUERY: begin
        next_rd_data = query_word(BUS.addr[7:0]);
      end
      default: begin
        next_rd_data = {8'h00, status_byte};
      end
    endcase
  end

  // state registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      mode    <= M_ARRAY;
      we_q    <= 1'b1;
      cnt     <= '0;
      vpp_bad <= 1'b0;
      st_vpp  <= 1'b0;
      st_seq  <= 1'b0;
      st_fail <= 1'b0;
      prot    <= 1'b1;
      rd_data <= '0;
      rd_oe   <= 1'b0;
    end else begin
      mode    <= next_mode;
      we_q    <= BUS.we_n;
      cnt     <= next_cnt;
      vpp_bad <= next_vpp_bad;
      st_vpp  <= next_st_vpp;
      st_seq  <= next_st_seq;
      st_fail <= next_st_fail;
      prot    <= next_prot;
      rd_data <= next_rd_data;
      rd_oe   <= next_rd_oe;
    end
  end

  // outputs
  assign BUS.dq_dev    = rd_data;
  assign BUS.dq_dev_oe = rd_oe;
  assign BUSY          = (mode == M_BUSY);
  assign PROTECTED     = prot;
  assign STATUS        = status_byte;
endmodule
`default_nettype wire

// *** rtl/flash_host.sv ***
// host end: runs the blocks-unprotect sequence and decodes the result
`timescale 1ns/1ps
`default_nettype none
module flash_host import flash_pkg::*; (
  input  wire logic              CLOCK,      // 50 mhz clock
  input  wire logic              NRST,       // async reset, low
  flash_bus_if.host              BUS,        // parallel flash bus
  input  wire logic              START,      // begin unprotect, pulse
  input  wire logic [ADDR_W-1:0] BLOCK_ADDR, // block address used
  output logic                   DONE,       // sequence over, pulse
  output result_type             RESULT,     // decoded outcome
  output logic                   BUSY        // sequence running
);
  typedef enum logic [2:0] {
    H_IDLE    = 3'b000,
    H_SETUP   = 3'b001,
    H_CONFIRM = 3'b010,
    H_POLL    = 3'b011,
    H_CLEAR   = 3'b100,
    H_ARRAY   = 3'b101
  } host_state_type;

  host_state_type    state;
  host_state_type    next_state;
  logic [2:0]        ph;
  logic [2:0]        next_ph;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] next_addr_q;
  result_type        result;
  result_type        next_result;
  logic              done;
  logic              next_done;
  logic [7:0]        cmd;
  logic              seen_ready;      // last poll showed ready
  logic              next_seen_ready;
  logic              in_op;
  logic              is_read;

  // command byte for each write step
  always_comb begin
    unique case (state)
      H_SETUP: cmd = CMD_UNPROT_SETUP;
      H_CONFIRM: cmd = CMD_CONFIRM;
      H_CLEAR: cmd = CMD_CLEAR_STATUS;
      H_ARRAY: cmd = CMD_READ_ARRAY;
      default: cmd = CMD_READ_ARRAY;
    endcase
  end

  // bus pins from state and phase
  assign in_op          = (state != H_IDLE);
  assign is_read        = (state == H_POLL);
  assign BUS.addr       = addr_q;
  assign BUS.ce_n       = !(in_op && ph != PH_LAST);
  assign BUS.we_n       = !(in_op && !is_read && ph >= PH_STROBE_ON && ph < PH_SAMPLE);
  assign BUS.oe_n       = !(is_read && ph >= PH_STROBE_ON && ph <= PH_SAMPLE);
  assign BUS.dq_host    = {8'h00, cmd};
  assign BUS.dq_host_oe = in_op && !is_read && ph != PH_LAST;

  // sequencer
  always_comb begin
    next_state  = state;
    next_ph     = ph;
    next_addr_q = addr_q;
    next_result = result;
    next_done   = 1'b0;
    next_seen_ready = seen_ready;
    if (state == H_IDLE) begin
      next_ph = '0;
      if (START) begin
        next_state  = H_SETUP;
        next_addr_q = BLOCK_ADDR;
      end
    end else if (is_read && ph == PH_SAMPLE) begin
      next_ph = ph + 3'h1;
      if (BUS.dq[ST_READY]) begin
        next_seen_ready = 1'b1;
        if (BUS.dq[ST_VPP_ERR]) begin
          next_result = RES_VPP;
        end else if (BUS.dq[ST_SEQ_ERR] && BUS.dq[ST_UNPROT_ERR]) begin
          next_result = RES_SEQ;
        end else if (BUS.dq[ST_UNPROT_ERR]) begin
          next_result = RES_FAIL;
        end else begin
          next_result = RES_OK;
        end
      end
    end else if (ph == PH_LAST) begin
      // poll tail cycle lets the device release dq before the next write
      next_ph = '0;
      unique case (state)
        H_SETUP: next_state = H_CONFIRM;
        H_CONFIRM: begin
          next_state      = H_POLL;
          next_seen_ready = 1'b0;
        end
        H_POLL: begin
          if (seen_ready) begin
            next_state = (result == RES_OK) ? H_ARRAY : H_CLEAR;
          end
        end
        H_CLEAR: next_state = H_ARRAY;
        H_ARRAY: begin
          next_state = H_IDLE;
          next_done  = 1'b1;
        end
        default: next_state = H_IDLE;
      endcase
    end else begin
      next_ph = ph + 3'h1;
    end
  end

  // registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state  <= H_IDLE;
      ph     <= '0;
      addr_q <= '0;
      result <= RES_OK;
      done   <= 1'b0;
      seen_ready <= 1'b0;
    end else begin
      state  <= next_state;
      ph     <= next_ph;
      addr_q <= next_addr_q;
      result <= next_result;
      done   <= next_done;
      seen_ready <= next_seen_ready;
    end
  end

  assign DONE   = done;
  assign RESULT = result;
  assign BUSY   = in_op;
endmodule
`default_nettype wire

// *** sim/flash_unprotect_and_query_asserts.sv ***
// concurrent checks on the bus joining host and device
`timescale 1ns/1ps
`default_nettype none
module flash_unprotect_and_query_asserts import flash_pkg::*; (
  input wire logic              CLOCK,      // 50 mhz clock
  input wire logic              NRST,       // async reset, low
  input wire logic              ce_n,       // chip enable
  input wire logic              oe_n,       // output enable
  input wire logic              we_n,       // write enable
  input wire logic [DATA_W-1:0] dq,         // resolved data
  input wire logic              dq_host_oe, // host drives dq
  input wire logic              dq_dev_oe   // device drives dq
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  logic       we_last; // we_n one edge back
  logic [7:0] cmd;     // command taken at this edge, else 00h
  // remember we_n to spot the rising edge
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      we_last <= 1'b1;
    end else begin
      we_last <= we_n;
    end
  end
  // command byte of a write taken now
  assign cmd = (!ce_n && !we_last && we_n) ? dq[7:0] : 8'h00;
  a_write_framed: assert property (!we_n |-> !ce_n && oe_n && dq_host_oe)
    else $error("write strobe outside a driven frame");
  a_confirm_follows: assert property (cmd == 8'h60 |-> ##[1:12] cmd == 8'hd0)
    else $error("confirm did not follow setup");
  a_read_answer: assert property (!ce_n && !oe_n |=> dq_dev_oe)
    else $error("device silent on a read");
  a_drive_cause: assert property (dq_dev_oe |-> !$past(ce_n) && !$past(oe_n))
    else $error("device drove without a read");
  a_no_clash: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive dq");
  a_busy_not_ready: assert property (cmd == 8'hd0 |=> (!dq_dev_oe || !dq[7])[*4])
    else $error("ready shown during unprotect");
  a_array_after: assert property (dq_dev_oe && dq[7] && !ce_n |-> ##[1:30] cmd == 8'hff)
    else $error("no array read command after ready");
  a_clear_on_error: assert property (dq_dev_oe && dq[7] && !ce_n && (dq[3] || dq[5])
    |-> ##[1:20] cmd == 8'h50) else $error("error left uncleared");
  a_ok_no_clear: assert property (dq_dev_oe && dq[7] && !ce_n && dq[5:3] == 3'b000
    |=> (cmd != 8'h50)[*8]) else $error("clear issued after success");
endmodule
`default_nettype wire

// *** sim/flash_unprotect_and_query_tb.sv ***
// bench: host and device joined, plus a bench-driven device
`timescale 1ns/1ps
`default_nettype none
module flash_unprotect_and_query_tb import flash_pkg::*; ;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  logic        vpp_ok = 1'b1;
  logic        fail_inject = 1'b0;
  logic        protect_all = 1'b0;
  logic        done, busy_h, busy1, busy2, prot1, prot2;
  result_type  result;
  logic [7:0]  stat1, stat2;
  logic [15:0] rdata;
  int          err_total = 0;
  int          samples_checked = 0;
  flash_bus_if b1();
  flash_bus_if b2();
  // 50 mhz clock
  always #10 clock = ~clock;
  // host and device joined, second device driven by the bench
  flash_host flash_host_i (.CLOCK(clock), .NRST(nrst), .BUS(b1.host), .START(start),
    .BLOCK_ADDR(21'h008000), .DONE(done), .RESULT(result), .BUSY(busy_h));
  flash_device #(.UNPROTECT_COUNT(8)) flash_device_i (.CLOCK(clock), .NRST(nrst),
    .BUS(b1.device), .VPP_OK(vpp_ok), .FAIL_INJECT(fail_inject), .PROTECT_ALL(protect_all),
    .ARRAY_DATA(16'h5a3c), .BUSY(busy1), .PROTECTED(prot1), .STATUS(stat1));
  flash_device #(.UNPROTECT_COUNT(8)) flash_device_i2 (.CLOCK(clock), .NRST(nrst),
    .BUS(b2.device), .VPP_OK(vpp_ok), .FAIL_INJECT(fail_inject), .PROTECT_ALL(protect_all),
    .ARRAY_DATA(16'h5a3c), .BUSY(busy2), .PROTECTED(prot2), .STATUS(stat2));
  flash_unprotect_and_query_asserts checker_i (.CLOCK(clock), .NRST(nrst), .ce_n(b1.ce_n),
    .oe_n(b1.oe_n), .we_n(b1.we_n), .dq(b1.dq), .dq_host_oe(b1.dq_host_oe),
    .dq_dev_oe(b1.dq_dev_oe));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // command write on the second bus
  task automatic wr2(input logic [7:0] c);
    @(posedge clock);
    b2.ce_n <= 1'b0;
    b2.dq_host <= {8'h00, c};
    b2.dq_host_oe <= 1'b1;
    @(posedge clock);
    b2.we_n <= 1'b0;
    repeat (2) @(posedge clock);
    b2.we_n <= 1'b1;
    @(posedge clock);
    b2.ce_n <= 1'b1;
    b2.dq_host_oe <= 1'b0;
  endtask
  // word read on the second bus
  task automatic rd2(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    b2.ce_n <= 1'b0;
    b2.addr <= {13'h0000, a};
    @(posedge clock);
    b2.oe_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1 d = b2.dq;
    @(posedge clock);
    b2.ce_n <= 1'b1;
    b2.oe_n <= 1'b1;
  endtask
  // host sequence from start to done, then judge it
  task automatic run_host(input result_type exp_res, input logic exp_prot);
    int n;
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({15'h0, done}, 16'h0001, "done");
    chk({14'h0, result}, {14'h0, exp_res}, "result");
    chk({15'h0, prot1}, {15'h0, exp_prot}, "protected");
    chk({8'h00, stat1}, 16'h0080, "status after sequence");
    chk({15'h0, busy_h}, 16'h0000, "host idle after sequence");
    chk({15'h0, busy1}, 16'h0000, "device idle after sequence");
  endtask
  // every query word except 3Ch, then array mode hides 48h
  task automatic t_query();
    logic [15:0] q [11] = '{16'h3b01, 16'h3f01, 16'h4080, 16'h4100, 16'h4203, 16'h4303,
      16'h4404, 16'h4503, 16'h4601, 16'h4702, 16'h4807};
    wr2(8'h98);
    for (int i = 0; i < 11; i++) begin
      rd2(q[i][15:8], rdata);
      chk(rdata, {8'h00, q[i][7:0]}, "query word");
    end
    wr2(8'hff);
    rd2(8'h48, rdata);
    chk(rdata, 16'h5a3c, "array read at query place");
  endtask
  // setup followed by a wrong code
  task automatic t_seq_err();
    wr2(8'h60);
    wr2(8'h70);
    rd2(8'h00, rdata);
    chk(rdata, 16'h00b0, "sequence error status");
    wr2(8'hff);
    chk({8'h00, stat2}, 16'h00b0, "error bits kept");
    wr2(8'h50);
    @(negedge clock);
    chk({8'h00, stat2}, 16'h0080, "error bits cleared");
    wr2(8'h70);
    rd2(8'h00, rdata);
    chk(rdata, 16'h0080, "status mode read after clear");
  endtask
  // unprotect polled by strobes only
  task automatic t_poll();
    wr2(8'h60);
    wr2(8'hd0);
    rd2(8'h00, rdata);
    chk(rdata, 16'h0000, "busy status");
    chk({15'h0, busy2}, 16'h0001, "busy flag during unprotect");
    chk({15'h0, prot2}, 16'h0001, "still protected");
    rd2(8'h00, rdata);
    chk(rdata, 16'h0080, "ready status");
    chk({15'h0, prot2}, 16'h0000, "unprotected");
    chk({15'h0, busy2}, 16'h0000, "busy flag after unprotect");
  endtask
  // supply error, then unprotect failure
  task automatic t_host_errors();
    @(posedge clock);
    protect_all <= 1'b1;
    vpp_ok <= 1'b0;
    @(posedge clock);
    protect_all <= 1'b0;
    run_host(RES_VPP, 1'b1);
    vpp_ok <= 1'b1;
    fail_inject <= 1'b1;
    run_host(RES_FAIL, 1'b1);
    fail_inject <= 1'b0;
  endtask
  // counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  // reset, then the scenarios
  initial begin
    b2.ce_n = 1'b1;
    b2.oe_n = 1'b1;
    b2.we_n = 1'b1;
    b2.addr = '0;
    b2.dq_host = '0;
    b2.dq_host_oe = 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_query();
    t_seq_err();
    t_poll();
    run_host(RES_OK, 1'b0);
    t_host_errors();
    complete_run();
  end
endmodule
`default_nettype wire
